// ### design/optical_conv_ctrl.sv
// conversion sequencer, burst, proximity and spike control of the readout
//
// Overview of operation
// - wait 4, 6, 8 or 12 us after LED on before integration, default 01.
// - filter select bit 0 picks filter type A, 1 picks type B.
// - burst repeat rate codes 0..3 give 8, 32, 84, 256 Hz.
// - with burst off, conversion cycles run continuously at the sample rate.
// - with burst on, conversions run at sample rate then idle until next burst.
// - with burst on, averaging count gives conversions per burst.
// - each burst ends with one averaged result per used slot into the FIFO.
// - burst size too large is cut to the table limit; disabled allows none.
// - sample rate too slow for the repeat rate clears the burst bit.
// - one conversion cycle walks the used sequence slots in order, skipping empty ones.
// - burst bit 0 disables, 1 enables burst conversion.
// - LED1 result at or above threshold leaves proximity mode, raises interrupt.
// - threshold compares against the 8 upper bits of the ADC count.
// - threshold 0xFF fires only on a saturated ADC result.
// - spike replacement runs only while its enable bit is 1, reset 0.
// - prediction uses last sample or a line through the previous four.
// - prediction order 0 is last sample, 1 (reset) is four-point line.
// - filter speed field sets deviation filter bandwidth, lowest narrowest.
// - deviation filter coefficient is 1/64, 1/32, 1/16 or 1/8.
// - spike when difference exceeds deviation times 4, 8, 16 or 32.
// - averaging counts are powers of two, 000 none, 111 is 128.
`timescale 1ns/1ps
`default_nettype none

module optical_conv_ctrl
  import optical_conv_pkg::*;
#(
  parameter int unsigned BurstCyc8Hz = BURST_CYC_0,
  parameter int unsigned BurstCyc32Hz = BURST_CYC_1,
  parameter int unsigned BurstCyc84Hz = BURST_CYC_2,
  parameter int unsigned BurstCyc256Hz = BURST_CYC_3
)(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port from the serial interface
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [REG_DW-1:0] regWrData,
  input wire logic regRdEn,
  output logic [REG_DW-1:0] regRdData,
  // settings held in neighbouring registers
  input wire logic [SR_W-1:0] sampleRateCode,
  input wire logic [AVE_W-1:0] sampleAveragingCount,
  input wire slot_codes_t sequenceSlots,
  // sample timebase from the sampling clock
  input wire logic sampleTick,
  // led drivers and photodiode front end
  output var led_req_t ledReq,
  input wire logic adcValid,
  input wire logic [ADC_W-1:0] adcData,
  // proximity
  input wire logic proxArm,
  output logic proxMode,
  output logic proxIrq,
  // fifo write side
  output logic fifoPush,
  output var fifo_word_t fifoWord,
  // static settings toward the analog side
  output var filter_type_t filterTypeSelect,
  output logic [BIAS_W-1:0] photodiodeBiasCode,
  output logic burstActive
);

  ctrl_state_t s_r, s_nxt;
  spike_cfg_t spkCfg;
  logic [SLOTS-1:0] spkInValid;
  logic [SLOTS-1:0] spkOutValid;
  logic [SLOTS-1:0] spkSeen;
  logic [SLOTS-1:0][ADC_W-1:0] spkOut;
  logic [3:0] curLimit;
  logic [3:0] newLimit;
  logic burstOn;
  logic [AVE_W-1:0] aveEff;
  logic [CYC_W-1:0] target;
  logic [3:0] firstSlot;
  logic [3:0] afterSlot;
  logic [SLOT_W-1:0] curCode;
  logic proxHit;
  logic [BURST_W-1:0] period;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [BURST_W-1:0] burstPeriod(logic [RATE_W-1:0] rate);
    case (rate)
      2'h0: return BURST_W'(BurstCyc8Hz);
      2'h1: return BURST_W'(BurstCyc32Hz);
      2'h2: return BURST_W'(BurstCyc84Hz);
      default: return BURST_W'(BurstCyc256Hz);
    endcase
  endfunction

  // lowest used slot at or after 'from'; bit 3 set when one exists
  function automatic logic [3:0] nextSlot(slot_codes_t sl, logic [3:0] from);
    logic [3:0] res;
    res = 4'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (4'(i) >= from && sl[i] != SLOT_NONE) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // one predictor per sequence slot, so slots never mix their history
  assign spkCfg = spike_cfg_t'(s_r.spikeCfg);

  for (genvar g = 0; g < SLOTS; g++) begin : g_spike
    assign spkInValid[g] = s_r.state == S_CONV && adcValid
                           && s_r.slotIdx == 3'(g);
    spike_fix u_spike (
      .clk(clk),
      .rstn(rstn),
      .cfg(spkCfg),
      .inValid(spkInValid[g]),
      .inData(adcData),
      .outValid(spkOutValid[g]),
      .outData(spkOut[g]),
      .spikeSeen(spkSeen[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.led.adcStart = 1'b0;
    s_nxt.proxIrq = 1'b0;
    s_nxt.fifoPush = 1'b0;

    curLimit = burstLimit(sampleRateCode, s_r.conf3[RATE_LSB +: RATE_W]);
    burstOn = s_r.conf3[BURST_BIT] && !curLimit[LIM_DIS_BIT];
    if (burstOn && sampleAveragingCount > curLimit[AVE_W-1:0]) begin
      aveEff = curLimit[AVE_W-1:0];
    end else begin
      aveEff = sampleAveragingCount;
    end
    target = CYC_W'(1) << aveEff;
    period = burstPeriod(s_r.conf3[RATE_LSB +: RATE_W]);
    firstSlot = nextSlot(sequenceSlots, 4'h0);
    afterSlot = nextSlot(sequenceSlots, {1'b0, s_r.slotIdx} + 4'h1);
    curCode = sequenceSlots[s_r.slotIdx];
    if (s_r.thresh == PROX_SAT) begin
      proxHit = &adcData;
    end else begin
      proxHit = adcData[ADC_W-1 -: THR_W] >= s_r.thresh[THR_W-1:0];
    end

    // register port; a read in a write cycle returns the old value
    if (regWrEn) begin
      if (regAddr == ADDR_CONF3) begin
        s_nxt.conf3 = regWrData & CONF3_MASK;
      end else if (regAddr == ADDR_THRESH) begin
        s_nxt.thresh = regWrData;
      end else if (regAddr == ADDR_BIAS) begin
        s_nxt.bias = regWrData & BIAS_MASK;
      end else if (regAddr == ADDR_SPIKE) begin
        s_nxt.spikeCfg = regWrData;
      end
    end
    newLimit = burstLimit(sampleRateCode, s_nxt.conf3[RATE_LSB +: RATE_W]);
    if (newLimit[LIM_DIS_BIT]) begin
      s_nxt.conf3[BURST_BIT] = 1'b0;
    end
    if (regRdEn) begin
      if (regAddr == ADDR_CONF3) begin
        s_nxt.rdData = s_r.conf3;
      end else if (regAddr == ADDR_THRESH) begin
        s_nxt.rdData = s_r.thresh;
      end else if (regAddr == ADDR_BIAS) begin
        s_nxt.rdData = s_r.bias;
      end else if (regAddr == ADDR_SPIKE) begin
        s_nxt.rdData = s_r.spikeCfg;
      end else begin
        s_nxt.rdData = '0;
      end
    end

    // conversion sequencer; sample ticks that land while busy are dropped
    case (s_r.state)
      S_IDLE: begin
        if (sampleTick && (!burstOn || s_r.burstArmed) && firstSlot[3]) begin
          s_nxt.slotIdx = firstSlot[2:0];
          s_nxt.settleCnt = settleCycles(
            s_r.conf3[SETTLE_LSB +: 2]) - SETTLE_W'(1);
          s_nxt.led.ledOn = 1'b1;
          s_nxt.led.slot = sequenceSlots[firstSlot[2:0]];
          s_nxt.state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (s_r.settleCnt == '0) begin
          s_nxt.led.adcStart = 1'b1;
          s_nxt.state = S_CONV;
        end else begin
          s_nxt.settleCnt = s_r.settleCnt - SETTLE_W'(1);
        end
      end
      S_CONV: begin
        if (adcValid) begin
          s_nxt.led.ledOn = 1'b0;
          if (curCode == SLOT_LED1 && s_r.proxMode && proxHit) begin
            s_nxt.proxMode = 1'b0;
            s_nxt.proxIrq = 1'b1;
          end
          s_nxt.state = S_FILT;
        end
      end
      S_FILT: begin
        if (spkOutValid[s_r.slotIdx]) begin
          s_nxt.acc[s_r.slotIdx] = s_r.acc[s_r.slotIdx]
                                   + ACC_W'(spkOut[s_r.slotIdx]);
          if (afterSlot[3]) begin
            s_nxt.slotIdx = afterSlot[2:0];
            s_nxt.settleCnt = settleCycles(
              s_r.conf3[SETTLE_LSB +: 2]) - SETTLE_W'(1);
            s_nxt.led.ledOn = 1'b1;
            s_nxt.led.slot = sequenceSlots[afterSlot[2:0]];
            s_nxt.state = S_SETTLE;
          end else if (s_r.cycCnt == target - CYC_W'(1)) begin
            s_nxt.cycCnt = '0;
            s_nxt.slotIdx = '0;
            s_nxt.state = S_PUSH;
          end else begin
            s_nxt.cycCnt = s_r.cycCnt + CYC_W'(1);
            s_nxt.state = S_IDLE;
          end
        end
      end
      S_PUSH: begin
        if (curCode != SLOT_NONE) begin
          s_nxt.fifoPush = 1'b1;
          s_nxt.fifoWord.slot = curCode;
          s_nxt.fifoWord.data = ADC_W'(s_r.acc[s_r.slotIdx] >> aveEff);
        end
        s_nxt.acc[s_r.slotIdx] = '0;
        if (s_r.slotIdx == 3'(SLOTS - 1)) begin
          s_nxt.burstArmed = 1'b0;
          s_nxt.state = S_IDLE;
        end else begin
          s_nxt.slotIdx = s_r.slotIdx + 3'h1;
        end
      end
      default: begin
        s_nxt.state = S_IDLE;
      end
    endcase

    // burst timer runs after the sequencer so a new period beats the clear
    if (!burstOn) begin
      s_nxt.burstCnt = '0;
      s_nxt.burstArmed = 1'b0;
    end else if (s_r.burstCnt >= period - BURST_W'(1)) begin
      s_nxt.burstCnt = '0;
      s_nxt.burstArmed = 1'b1;
    end else begin
      s_nxt.burstCnt = s_r.burstCnt + BURST_W'(1);
    end

    // arming wins over a hit in the same cycle
    if (proxArm) begin
      s_nxt.proxMode = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.conf3 <= CONF3_RST;
      s_r.thresh <= THRESH_RST;
      s_r.bias <= BIAS_RST;
      s_r.spikeCfg <= SPIKE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign regRdData = s_r.rdData;
  assign ledReq = s_r.led;
  assign proxMode = s_r.proxMode;
  assign proxIrq = s_r.proxIrq;
  assign fifoPush = s_r.fifoPush;
  assign fifoWord = s_r.fifoWord;
  assign filterTypeSelect = filter_type_t'(s_r.conf3[FILT_BIT]);
  assign photodiodeBiasCode = s_r.bias[BIAS_W-1:0];
  assign burstActive = s_r.conf3[BURST_BIT];

endmodule // optical_conv_ctrl

`default_nettype wire

// ### design/optical_conv_pkg.sv
// shared constants, types and tables of the optical conversion controller
package optical_conv_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam int ADC_W = 19;
  localparam int SLOTS = 6;
  localparam int SLOT_W = 4;
  localparam int AVE_W = 3;
  localparam int SR_W = 5;
  localparam int BIAS_W = 3;
  localparam int RATE_W = 2;
  localparam int ACC_W = ADC_W + 7;
  localparam int SETTLE_W = 9;
  localparam int BURST_W = 23;
  localparam int CYC_W = 8;
  localparam int HIST = 4;
  localparam int THR_W = 8;
  localparam int SIGMA_FRAC = 6;
  localparam int PRED_W = ADC_W + 3;
  localparam int SIG_W = PRED_W + SIGMA_FRAC;
  localparam int GAIN_MAX_SHIFT = 5;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [REG_AW-1:0] ADDR_CONF3 = 8'h13;
  localparam logic [REG_AW-1:0] ADDR_THRESH = 8'h14;
  localparam logic [REG_AW-1:0] ADDR_BIAS = 8'h15;
  localparam logic [REG_AW-1:0] ADDR_SPIKE = 8'h16;
  localparam logic [REG_DW-1:0] CONF3_RST = 8'h40;
  localparam logic [REG_DW-1:0] THRESH_RST = 8'h00;
  localparam logic [REG_DW-1:0] BIAS_RST = 8'h00;
  localparam logic [REG_DW-1:0] SPIKE_RST = 8'h40;
  localparam logic [REG_DW-1:0] CONF3_MASK = 8'hE7;
  localparam logic [REG_DW-1:0] BIAS_MASK = 8'h07;
  localparam int SETTLE_LSB = 6;
  localparam int FILT_BIT = 5;
  localparam int RATE_LSB = 1;
  localparam int BURST_BIT = 0;
  localparam int LIM_DIS_BIT = 3;
  localparam logic [SLOT_W-1:0] SLOT_NONE = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_LED1 = 4'h1;
  localparam logic [THR_W-1:0] PROX_SAT = 8'hFF;

  // led settling times in ns, and burst repeat rates in Hz
  localparam int SETTLE_NS_0 = 4000;
  localparam int SETTLE_NS_1 = 6000;
  localparam int SETTLE_NS_2 = 8000;
  localparam int SETTLE_NS_3 = 12000;
  localparam int BURST_HZ_0 = 8;
  localparam int BURST_HZ_1 = 32;
  localparam int BURST_HZ_2 = 84;
  localparam int BURST_HZ_3 = 256;
  localparam int BURST_CYC_0 = CLK_HZ / BURST_HZ_0;
  localparam int BURST_CYC_1 = CLK_HZ / BURST_HZ_1;
  localparam int BURST_CYC_2 = CLK_HZ / BURST_HZ_2;
  localparam int BURST_CYC_3 = CLK_HZ / BURST_HZ_3;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic {FILTER_TYPE_A, FILTER_TYPE_B} filter_type_t;
  typedef logic [SLOTS-1:0][SLOT_W-1:0] slot_codes_t;
  typedef struct packed {
    logic on;
    logic order;
    logic [1:0] speed;
    logic [1:0] start;
    logic [1:0] gain;
  } spike_cfg_t;
  typedef struct packed {
    logic ledOn;
    logic [SLOT_W-1:0] slot;
    logic adcStart;
  } led_req_t;
  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic [ADC_W-1:0] data;
  } fifo_word_t;
  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_CONV, S_FILT, S_PUSH}
    conv_state_t;
  typedef struct packed {
    logic [REG_DW-1:0] conf3;
    logic [REG_DW-1:0] thresh;
    logic [REG_DW-1:0] bias;
    logic [REG_DW-1:0] spikeCfg;
    logic [REG_DW-1:0] rdData;
    conv_state_t state;
    logic [2:0] slotIdx;
    logic [SETTLE_W-1:0] settleCnt;
    logic [CYC_W-1:0] cycCnt;
    logic [BURST_W-1:0] burstCnt;
    logic burstArmed;
    logic [SLOTS-1:0][ACC_W-1:0] acc;
    led_req_t led;
    logic proxMode;
    logic proxIrq;
    logic fifoPush;
    fifo_word_t fifoWord;
  } ctrl_state_t;
  typedef struct packed {
    logic [HIST-1:0][ADC_W-1:0] hist;
    logic [2:0] filled;
    logic [SIG_W-1:0] sigma;
    logic outValid;
    logic [ADC_W-1:0] outData;
    logic spike;
  } spike_state_t;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [SETTLE_W-1:0] settleCycles(logic [1:0] code);
    int ns;
    case (code)
      2'h0: ns = SETTLE_NS_0;
      2'h1: ns = SETTLE_NS_1;
      2'h2: ns = SETTLE_NS_2;
      default: ns = SETTLE_NS_3;
    endcase
    return SETTLE_W'((ns * CLK_MHZ + 999) / 1000);
  endfunction

  // nibble per repeat rate, rate 3 in the top nibble; 4'h8 means disabled
  function automatic logic [3:0] burstLimit(logic [SR_W-1:0] sr,
                                            logic [RATE_W-1:0] rate);
    logic [15:0] row;
    case (sr)
      5'h00, 5'h06, 5'h0C: row = 16'h8881;
      5'h01, 5'h07, 5'h0D: row = 16'h8802;
      5'h02, 5'h03, 5'h08, 5'h09: row = 16'h8813;
      5'h04: row = 16'h8024;
      5'h05: row = 16'h8135;
      5'h0B: row = 16'h8880;
      5'h0E: row = 16'h8013;
      5'h0F: row = 16'h8124;
      5'h10: row = 16'h8235;
      5'h11: row = 16'h0346;
      5'h12: row = 16'h1457;
      5'h13: row = 16'h2567;
      default: row = 16'h8888;
    endcase
    return row[{rate, 2'h0} +: 4];
  endfunction

  function automatic int devShift(logic [1:0] code);
    return 6 - int'(code);
  endfunction

  function automatic int gainShift(logic [1:0] code);
    return 2 + int'(code);
  endfunction

  function automatic logic [6:0] startSigma(logic [1:0] code);
    case (code)
      2'h0: return 7'h40;
      2'h1: return 7'h30;
      2'h2: return 7'h20;
      default: return 7'h18;
    endcase
  endfunction

endpackage

// ### design/spike_fix.sv
// spike detect-and-replace for one sample stream
`timescale 1ns/1ps
`default_nettype none

module spike_fix
  import optical_conv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // settings
  input wire spike_cfg_t cfg,
  // sample in
  input wire logic inValid,
  input wire logic [ADC_W-1:0] inData,
  // sample out, one cycle later
  output logic outValid,
  output logic [ADC_W-1:0] outData,
  output logic spikeSeen
);

  spike_state_t s_r, s_nxt;
  logic signed [PRED_W-1:0] lin, diff;
  logic [ADC_W-1:0] pred;
  logic [PRED_W-1:0] dev;
  logic [SIG_W-1:0] devFix;
  logic signed [SIG_W:0] delta;
  logic [SIG_W+GAIN_MAX_SHIFT-1:0] limit;
  logic hit;

  always_comb begin
    s_nxt = s_r;
    s_nxt.outValid = inValid;
    // straight line through the last four, evaluated one step ahead
    lin = ($signed({2'b00, s_r.hist[0], 1'b0}) + $signed({3'b000, s_r.hist[1]})
          - $signed({3'b000, s_r.hist[3]})) >>> 1;
    if (!cfg.order || s_r.filled < 3'(HIST)) begin
      pred = s_r.hist[0];
    end else if (lin < 0) begin
      pred = '0;
    end else if (lin > $signed({3'b000, {ADC_W{1'b1}}})) begin
      pred = {ADC_W{1'b1}};
    end else begin
      pred = lin[ADC_W-1:0];
    end
    diff = $signed({3'b000, inData}) - $signed({3'b000, pred});
    dev = (diff < 0) ? PRED_W'(-diff) : PRED_W'(diff);
    devFix = {dev, {SIGMA_FRAC{1'b0}}};
    delta = $signed({1'b0, devFix}) - $signed({1'b0, s_r.sigma});
    limit = {{GAIN_MAX_SHIFT{1'b0}}, s_r.sigma} << gainShift(cfg.gain);
    hit = cfg.on && s_r.filled == 3'(HIST)
          && {{GAIN_MAX_SHIFT{1'b0}}, devFix} > limit;
    if (!cfg.on) begin
      s_nxt.sigma = SIG_W'(startSigma(cfg.start)) << SIGMA_FRAC;
    end
    if (inValid) begin
      s_nxt.spike = hit;
      s_nxt.outData = hit ? pred : inData;
      s_nxt.hist = {s_r.hist[HIST-2:0], s_nxt.outData};
      if (s_r.filled != 3'(HIST)) begin
        s_nxt.filled = s_r.filled + 3'h1;
      end
      if (cfg.on) begin
        s_nxt.sigma = SIG_W'($signed({1'b0, s_r.sigma})
                      + (delta >>> devShift(cfg.speed)));
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign outValid = s_r.outValid;
  assign outData = s_r.outData;
  assign spikeSeen = s_r.spike;

endmodule // spike_fix

`default_nettype wire

// ### tb/optical_conv_ctrl_assertions.sv
// port assertions of the optical conversion controller
`timescale 1ns/1ps
`default_nettype none

module optical_conv_ctrl_assertions
  import optical_conv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port and settings
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [REG_DW-1:0] regWrData,
  input wire logic regRdEn,
  input wire logic [REG_DW-1:0] regRdData,
  input wire logic [SR_W-1:0] sampleRateCode,
  // conversion link and status
  input wire led_req_t ledReq,
  input wire logic adcValid,
  input wire logic proxArm,
  input wire logic proxMode,
  input wire logic proxIrq,
  input wire filter_type_t filterTypeSelect,
  input wire logic [BIAS_W-1:0] photodiodeBiasCode,
  input wire logic burstActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  // settle code shadow, led-on cycles
  logic [1:0] settleCode_r;
  logic [9:0] onCnt_r;
  logic [9:0] settleN;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settleCode_r <= 2'h1;
      onCnt_r <= 10'h0;
    end else begin
      if (regWrEn && regAddr == ADDR_CONF3) begin
        settleCode_r <= regWrData[7:6];
      end
      onCnt_r <= ledReq.ledOn ? onCnt_r + 10'h1 : 10'h0;
    end
  end
  assign settleN = settleCode_r == 2'h3 ? 10'h1E0
    : 10'hA0 + 10'h50 * settleCode_r;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_convDone;
    ledReq.ledOn && adcValid;
  endsequence
  property p_settle;
    ledReq.adcStart |-> onCnt_r == settleN;
  endproperty
  a_settle: assert property (p_settle)
    else $error("settle time");
  property p_startPulse;
    ledReq.adcStart |=> !ledReq.adcStart && ledReq.ledOn;
  endproperty
  a_startPulse: assert property (p_startPulse)
    else $error("start pulse");
  property p_ledRelease;
    s_convDone |=> !ledReq.ledOn;
  endproperty
  a_ledRelease: assert property (p_ledRelease)
    else $error("led not off");
  property p_filt;
    regWrEn && regAddr == ADDR_CONF3 |=>
      filterTypeSelect == $past(regWrData[FILT_BIT]);
  endproperty
  a_filt: assert property (p_filt)
    else $error("filter select");
  property p_bias;
    regWrEn && regAddr == ADDR_BIAS |=>
      photodiodeBiasCode == $past(regWrData[2:0]);
  endproperty
  a_bias: assert property (p_bias)
    else $error("bias code");
  property p_unmapped;
    regRdEn && (regAddr < ADDR_CONF3 || regAddr > ADDR_SPIKE) |=>
      regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read");
  property p_burstDis;
    sampleRateCode == 5'h0A || sampleRateCode > 5'h13 |=> !burstActive;
  endproperty
  a_burstDis: assert property (p_burstDis)
    else $error("burst kept");
  property p_burstOff;
    regWrEn && regAddr == ADDR_CONF3 && !regWrData[BURST_BIT] |=>
      !burstActive;
  endproperty
  a_burstOff: assert property (p_burstOff)
    else $error("burst on");
  property p_prox;
    proxIrq |-> $past(proxMode) && $past(adcValid)
      && (!proxMode || $past(proxArm));
  endproperty
  a_prox: assert property (p_prox)
    else $error("prox irq");
endmodule // optical_conv_ctrl_assertions

bind optical_conv_ctrl optical_conv_ctrl_assertions u_chk (
  .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
  .sampleRateCode(sampleRateCode), .ledReq(ledReq), .adcValid(adcValid),
  .proxArm(proxArm), .proxMode(proxMode), .proxIrq(proxIrq),
  .filterTypeSelect(filterTypeSelect),
  .photodiodeBiasCode(photodiodeBiasCode), .burstActive(burstActive)
);

`default_nettype wire

// ### tb/led_front_end_model.sv
// behavioural led drivers and photodiode front end
`timescale 1ns/1ps
`default_nettype none

module led_front_end_model
  import optical_conv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request, scene, conversion time
  input wire led_req_t ledReq,
  input wire logic [ADC_W-1:0] level,
  input wire logic [3:0] convDelay,
  // result
  output logic adcValid,
  output logic [ADC_W-1:0] adcData
);
  int cnt;
  logic [ADC_W-1:0] last;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      last <= '0;
      adcValid <= 1'b0;
      adcData <= '0;
    end else begin
      // slot code keeps slots apart
      if (ledReq.adcStart) begin
        cnt <= int'(convDelay) + 1;
        last <= level + ADC_W'(ledReq.slot);
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      adcValid <= (cnt == 1);
      // inverse once the pulse is over
      adcData <= (cnt == 1) ? last : ~last;
    end
  end
endmodule // led_front_end_model

`default_nettype wire

// ### tb/test_optical_conv_ctrl.sv
// self-checking bench of the optical conversion controller
`timescale 1ns/1ps
`default_nettype none

module test_optical_conv_ctrl;
  import optical_conv_pkg::*;
  logic clk, rstn, regWrEn, regRdEn, sampleTick, proxArm, adcValid;
  logic [REG_AW-1:0] regAddr;
  logic [REG_DW-1:0] regWrData, regRdData;
  logic [SR_W-1:0] sampleRateCode;
  logic [AVE_W-1:0] sampleAveragingCount;
  slot_codes_t sequenceSlots;
  led_req_t ledReq;
  logic [ADC_W-1:0] adcData, level;
  logic [3:0] convDelay;
  logic proxMode, proxIrq, fifoPush, burstActive;
  fifo_word_t fifoWord;
  filter_type_t filterTypeSelect;
  logic [BIAS_W-1:0] photodiodeBiasCode;
  int error_cnt = 0, total_checks = 0, cyc = 0, irqCnt = 0;
  fifo_word_t pushQ[$];

  optical_conv_ctrl #(.BurstCyc8Hz(200), .BurstCyc32Hz(100),
    .BurstCyc84Hz(60), .BurstCyc256Hz(40)) u_dut (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .sampleRateCode(sampleRateCode),
    .sampleAveragingCount(sampleAveragingCount),
    .sequenceSlots(sequenceSlots), .sampleTick(sampleTick),
    .ledReq(ledReq), .adcValid(adcValid), .adcData(adcData),
    .proxArm(proxArm), .proxMode(proxMode), .proxIrq(proxIrq),
    .fifoPush(fifoPush), .fifoWord(fifoWord),
    .filterTypeSelect(filterTypeSelect),
    .photodiodeBiasCode(photodiodeBiasCode), .burstActive(burstActive));
  led_front_end_model u_fe (.clk(clk), .rstn(rstn), .ledReq(ledReq),
    .level(level), .convDelay(convDelay), .adcValid(adcValid),
    .adcData(adcData));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (rstn && fifoPush) pushQ.push_back(fifoWord);
    if (rstn && proxIrq) irqCnt++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrReg(logic [7:0] a, logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chkReg(logic [7:0] a, logic [7:0] exp);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    check("register", regRdData, exp);
  endtask
  task automatic wrChk(logic [7:0] a, logic [7:0] d, logic [7:0] e);
    wrReg(a, d);
    chkReg(a, e);
  endtask
  task automatic convCycle(logic [ADC_W-1:0] lv);
    int n = 0;
    level <= lv;
    convDelay <= 4'($urandom_range(0, 9));
    sampleTick <= 1'b1;
    @(posedge clk);
    sampleTick <= 1'b0;
    for (int i = 0; i < 2000 && n < 2; i++) begin
      @(posedge clk);
      if (adcValid) n++;
    end
    repeat (12) @(posedge clk);
  endtask
  task automatic arm();
    proxArm <= 1'b1;
    @(posedge clk);
    proxArm <= 1'b0;
    @(posedge clk);
    check("proxMode", proxMode, 1'b1);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, t;
    logic [ADC_W-1:0] lv;
    int s0;
    {rstn, regWrEn, regRdEn, sampleTick, proxArm} = '0;
    {regAddr, regWrData, level, convDelay} = '0;
    sampleRateCode = 5'h11;
    sampleAveragingCount = 3'h0;
    sequenceSlots = 24'h000021;
    d = 8'($urandom(32'h7997769C));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chkReg(ADDR_CONF3, CONF3_RST);
    chkReg(ADDR_THRESH, THRESH_RST);
    chkReg(ADDR_BIAS, BIAS_RST);
    chkReg(ADDR_SPIKE, SPIKE_RST);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom());
      wrChk(ADDR_CONF3, d & 8'hFE, d & 8'hE6);
      check("filter", filterTypeSelect, d[5]);
      wrChk(ADDR_THRESH, d, d);
      wrChk(ADDR_BIAS, ~d, ~d & BIAS_MASK);
      wrChk(ADDR_SPIKE, d ^ 8'h5A, d ^ 8'h5A);
    end
    wrChk(8'h17, 8'hFF, 8'h00);
    sampleRateCode <= 5'h0A;
    wrChk(ADDR_CONF3, 8'h01, 8'h00);
    sampleRateCode <= 5'h13;
    wrChk(ADDR_CONF3, 8'h07, 8'h07);
    check("burst", burstActive, 1'b1);
    sampleRateCode <= 5'h00;
    repeat (2) @(posedge clk);
    chkReg(ADDR_CONF3, 8'h06);
    check("burst", burstActive, 1'b0);
    sampleRateCode <= 5'h11;
    wrReg(ADDR_CONF3, 8'h00);
    wrReg(ADDR_SPIKE, SPIKE_RST);
    for (int c = 0; c < 3; c++) begin
      sampleAveragingCount <= 3'(c);
      pushQ.delete();
      s0 = 0;
      for (int k = 0; k < (1 << c); k++) begin
        lv = 19'($urandom_range(0, 19'h3FFFF));
        s0 += int'(lv) + 1;
        convCycle(lv);
      end
      check("pushes", pushQ.size(), 2);
      check("slot0", pushQ[0], {SLOT_LED1, 19'(s0 >> c)});
      check("slot1", pushQ[1], {4'h2, 19'((s0 + (1 << c)) >> c)});
    end
    sampleAveragingCount <= 3'h0;
    t = 8'($urandom_range(1, 8'hFE));
    wrReg(ADDR_THRESH, t);
    arm();
    irqCnt = 0;
    convCycle({t - 8'h1, 11'h7FE});
    check("irq below", irqCnt, 0);
    convCycle({t, 11'h0} - 19'h1);
    check("irq at", irqCnt, 1);
    check("proxMode", proxMode, 1'b0);
    wrReg(ADDR_THRESH, PROX_SAT);
    arm();
    convCycle(19'h7FFFD);
    check("irq unsat", irqCnt, 1);
    convCycle(19'h7FFFE);
    check("irq sat", irqCnt, 2);
    wrReg(ADDR_SPIKE, 8'h83);
    pushQ.delete();
    convCycle(19'h7FFFD);
    convCycle(19'h0);
    check("spike pass", pushQ[0], {SLOT_LED1, 19'h7FFFE});
    check("spike fix", pushQ[2], {SLOT_LED1, 19'h7FFFE});
    end_of_test();
  end
endmodule // test_optical_conv_ctrl

`default_nettype wire
